// ==== tb/rxl_checker.sv ====
// Purpose: Port-level assertions for rxl_top
// Assumes: One clock, synchronous active-high reset
// Notes: Bound to every rxl_top instance at the foot of this file
`timescale 1ns/10ps
`default_nettype none

module rxl_checker #(
	parameter int NUM_CH = 17
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [NUM_CH-1:0] recovered_clock_in,
	input wire logic [NUM_CH-1:0] rx_pos_in,
	input wire logic [NUM_CH-1:0] rx_neg_in,
	input wire logic [NUM_CH-1:0] line_loss_in,
	input wire logic [NUM_CH-1:0] recovered_rx_clock_out,
	input wire logic [NUM_CH-1:0] recovered_rx_clock_oe,
	input wire logic [NUM_CH-1:0] rx_positive_rail_data,
	input wire logic [NUM_CH-1:0] rx_data_oe,
	input wire logic reference_clock_output,
	input wire logic serial_line_loss_status,
	input wire logic serial_line_loss_status_oe,
	input wire logic channel_zero_slot_marker,
	input wire logic channel_zero_slot_marker_oe
);
	// ==========
	// Slot tracking
	logic [4:0] gap_q;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Slots since the marker; 16 means channel 0 is due next
	always_ff @(posedge sys_clk)
	begin
		if (rst)
			gap_q <= 5'h10;
		else if ($rose(reference_clock_output))
			gap_q <= channel_zero_slot_marker ? 5'h00 : gap_q + 5'h01;
		else if (!channel_zero_slot_marker_oe)
			gap_q <= 5'h10;
	end

	// ==========
	// Receive pins
	clk_cause_a: assert property (
		(recovered_rx_clock_out & ~$past(recovered_clock_in | line_loss_in | (rx_pos_in ^ rx_neg_in))) == '0)
		else $error("rx clock pin high with no cause");
	clk_pd_low_a: assert property (
		(recovered_rx_clock_out & ~recovered_rx_clock_oe) == '0) else $error("undriven clock pin not low");
	data_pd_low_a: assert property (
		(rx_positive_rail_data & ~rx_data_oe) == '0) else $error("undriven data pin not low");
	pd_oe_match_a: assert property (
		rx_data_oe == recovered_rx_clock_oe) else $error("data and clock enables differ");

	// ==========
	// Serial status stream
	los_edge_a: assert property (
		$changed(serial_line_loss_status) && reference_clock_output |-> $rose(reference_clock_output))
		else $error("stream moved off reference rise");
	mark_edge_a: assert property (
		$changed(channel_zero_slot_marker) && reference_clock_output |-> $rose(reference_clock_output))
		else $error("marker moved off reference rise");
	los_idle_a: assert property (
		!serial_line_loss_status_oe |-> !serial_line_loss_status) else $error("stream active while idle");
	mark_idle_a: assert property (
		!channel_zero_slot_marker_oe |-> !channel_zero_slot_marker) else $error("marker active while idle");
	slot_cycle_a: assert property (
		$rose(reference_clock_output) |-> channel_zero_slot_marker == (gap_q == 5'h10))
		else $error("marker not once per seventeen slots");

	// ==========
	// Register bus answers hold until taken
	bresp_hold_a: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
	rdata_hold_a: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
endmodule

bind rxl_top rxl_checker #(.NUM_CH(NUM_CH)) u_rxl_checker (.*);
`default_nettype wire

// ==== tb/rxl_framer_model.sv ====
// Purpose: Framer-side receiver of the serial line-loss stream
// Assumes: Stream sampled one sys_clk after each reference rise
// Notes: Rebuilds one 17-bit word per marked frame, bit n = channel n
`timescale 1ns/10ps
`default_nettype none

module rxl_framer_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic reference_clock_output,
	input wire logic serial_line_loss_status,
	input wire logic channel_zero_slot_marker,
	output logic [16:0] word_q,
	output logic [7:0] frames_q,
	output logic [7:0] period_q
);
	// ==========
	// Frame capture
	logic ref_q;
	logic rise;
	logic [4:0] slot_q;
	logic [16:0] acc_q;
	logic [7:0] span_q;

	assign rise = reference_clock_output && !ref_q;

	// Unsynced until a marker, so a partial first frame is never reported
	always_ff @(posedge sys_clk)
	begin
		ref_q <= reference_clock_output;
		span_q <= rise ? 8'h01 : span_q + 8'h01;
		if (rst)
		begin
			slot_q <= 5'h00;
			frames_q <= 8'h00;
		end
		else if (rise)
		begin
			period_q <= span_q;
			acc_q <= {serial_line_loss_status, acc_q[16:1]};
			if (channel_zero_slot_marker)
				slot_q <= 5'h01;
			else
				slot_q <= (slot_q == 5'h00 || slot_q == 5'h10) ? 5'h00 : slot_q + 5'h01;
			if (slot_q == 5'h10 && !channel_zero_slot_marker)
			begin
				word_q <= {serial_line_loss_status, acc_q[16:1]};
				frames_q <= frames_q + 8'h01;
			end
		end
	end
endmodule
`default_nettype wire

// ==== tb/rxl_top_tb.sv ====
// Purpose: Self-checking bench for rxl_top
// Assumes: Short reference half periods of 4 and 2 cycles
// Notes: Register access through AXI4-Lite tasks only
`timescale 1ns/10ps
`default_nettype none
`include "rxl_params.svh"

module rxl_top_tb
	import rxl_pkg::*;
;
	// ==========
	// Signals
	logic sys_clk, rst, reference_master_clock, los_word_valid, los_word_ready, reference_clock_output;
	logic [7:0] s_axi_awaddr, s_axi_araddr, frames, period;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [16:0] recovered_clock_in, rx_pos_in, rx_neg_in, line_loss_in, los_word_data, seen_word;
	logic [16:0] recovered_rx_clock_out, recovered_rx_clock_oe, rx_positive_rail_data, rx_negative_rail_data;
	logic [16:0] rx_data_oe;
	logic serial_line_loss_status, serial_line_loss_status_oe, channel_zero_slot_marker, channel_zero_slot_marker_oe;
	int fail_count, n_compared;
	localparam logic [16:0] EDGE_D [5] = '{17'h1AAAA, 17'h1AAAA, 17'h05555, 17'h0F00F, 17'h0F00F};
	localparam logic [16:0] EDGE_E [5] = '{17'h0F0F0, 17'h1AAAA, 17'h1AAAA, 17'h1AAAA, 17'h0F00F};
	localparam logic [4:0] EDGE_C = 5'h0A;

	rxl_top #(.HALF_SLOW_CYC(4), .HALF_FAST_CYC(2)) u_dut (.*);

	rxl_framer_model u_framer (.sys_clk, .rst, .reference_clock_output, .serial_line_loss_status,
		.channel_zero_slot_marker, .word_q(seen_word), .frames_q(frames), .period_q(period));

	// 100 MHz clock
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// ==========
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Address and data offered together, each dropped once taken
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		while (!(aw_done && w_done))
		begin
			s_axi_awvalid <= !aw_done;
			s_axi_wvalid <= !w_done;
			@(posedge sys_clk);
			aw_done = aw_done | s_axi_awready;
			w_done = w_done | s_axi_wready;
		end
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		// Late ready so the slave must hold its answer
		repeat (2) @(posedge sys_clk);
		s_axi_bready <= 1'b1;
		do
			@(posedge sys_clk);
		while (!s_axi_bvalid);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do
			@(posedge sys_clk);
		while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		@(posedge sys_clk);
		s_axi_rready <= 1'b1;
		do
			@(posedge sys_clk);
		while (!s_axi_rvalid);
		rd = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask

	// Valid stays up between pushes; the caller drops it
	task automatic push(input logic [16:0] d);
		los_word_data <= d;
		los_word_valid <= 1'b1;
		do
			@(posedge sys_clk);
		while (!los_word_ready);
	endtask

	task automatic wait_frame();
		logic [7:0] f;
		int i;
		f = frames;
		for (i = 0; i < 400 && frames === f; i++)
			@(posedge sys_clk);
	endtask

	task automatic edge_step(input logic c, input logic [16:0] d);
		rx_pos_in <= d;
		recovered_clock_in <= {17{c}};
		repeat (4) @(posedge sys_clk);
	endtask

	function automatic logic [16:0] word(input int k);
		return 17'(32'h1F0E1 ^ (k * 32'h0A5B));
	endfunction

	task automatic wrap_up();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Whole run is near 2500 cycles; sixteen times that is a hang
	initial
	begin
		#400000;
		fail_count++;
		wrap_up();
	end

	// ==========
	// Tests
	initial
	begin
		rst = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, los_word_valid} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, los_word_data, reference_master_clock} = '0;
		{recovered_clock_in, rx_pos_in, rx_neg_in, line_loss_in} = '0;
		s_axi_wstrb = 4'hF;
		fail_count = 0;
		n_compared = 0;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		axi_rd(`RXL_OFS_CONFIG_ONE);
		chk(rd, 32'h0);
		axi_rd(8'h18);
		chk(32'(resp), 32'(`RXL_RESP_SLVERR));
		axi_wr(`RXL_OFS_STATUS, 32'h1);
		chk(32'(resp), 32'(`RXL_RESP_SLVERR));
		$display("test registers done");
		recovered_clock_in <= 17'h15A5A;
		repeat (3) @(posedge sys_clk);
		chk(32'(recovered_rx_clock_out), 32'h15A5A);
		line_loss_in <= 17'h000FF;
		repeat (3) @(posedge sys_clk);
		chk(32'(recovered_rx_clock_out), 32'h15AFF);
		axi_wr(`RXL_OFS_CONFIG_ZERO, 32'h80);
		repeat (3) @(posedge sys_clk);
		chk(32'(recovered_rx_clock_out), 32'h15A00);
		reference_master_clock <= 1'b1;
		rx_pos_in <= 17'h0F0F0;
		rx_neg_in <= 17'h0FF00;
		repeat (3) @(posedge sys_clk);
		chk(32'(recovered_rx_clock_out), 32'h15AFF);
		axi_wr(`RXL_OFS_CONFIG_ONE, 32'(RXL_FMT_DUAL_SLICED));
		repeat (3) @(posedge sys_clk);
		chk(32'(recovered_rx_clock_out), 32'h00FF0);
		$display("test clock pin done");
		axi_wr(`RXL_OFS_CONFIG_ONE, 32'(RXL_FMT_DUAL_NRZ));
		rx_neg_in <= 17'h0;
		for (int i = 0; i < 5; i++)
		begin
			if (i == 3)
				axi_wr(`RXL_OFS_CONFIG_ONE, 32'h11);
			edge_step(EDGE_C[i], EDGE_D[i]);
			chk(32'(rx_positive_rail_data), 32'(EDGE_E[i]));
		end
		$display("test edge select done");
		axi_wr(`RXL_OFS_POWERDOWN, 32'h1FFFF);
		for (int i = 0; i < 2; i++)
		begin
			axi_wr(`RXL_OFS_CONFIG_ZERO, i ? 32'h0 : 32'h40);
			repeat (3) @(posedge sys_clk);
			chk(32'(recovered_rx_clock_oe), i ? 32'h1FFFF : 32'h0);
			chk(32'(rx_data_oe), i ? 32'h1FFFF : 32'h0);
			chk(32'(recovered_rx_clock_out | rx_positive_rail_data), 32'h0);
		end
		$display("test powerdown done");
		for (int k = 0; k < 16; k++)
			push(word(k));
		los_word_valid <= 1'b0;
		repeat (2) @(posedge sys_clk);
		chk(32'(los_word_ready), 32'h0);
		axi_rd(`RXL_OFS_STATUS);
		chk(32'(rd[15:8]), 32'h10);
		axi_wr(`RXL_OFS_REF_CTRL, 32'h1);
		for (int k = 0; k < 16; k++)
		begin
			wait_frame();
			chk(32'(seen_word), 32'(word(k)));
		end
		chk(32'(period), 32'h8);
		chk(32'({serial_line_loss_status_oe, channel_zero_slot_marker_oe}), 32'h3);
		axi_rd(`RXL_OFS_STATUS);
		chk(32'(rd[15:8]), 32'h0);
		axi_wr(`RXL_OFS_REF_CTRL, 32'h3);
		wait_frame();
		wait_frame();
		chk(32'(period), 32'h4);
		chk(32'(seen_word), 32'(word(15)));
		axi_wr(`RXL_OFS_REF_CTRL, 32'h0);
		repeat (4) @(posedge sys_clk);
		chk(32'({serial_line_loss_status_oe, channel_zero_slot_marker_oe}), 32'h0);
		$display("test serial stream done");
		wrap_up();
	end
endmodule
`default_nettype wire

// ==== verilog/rxl_fifo.sv ====
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: One clock, synchronous active-high reset
// Notes: Ready and valid come from flip-flops
`timescale 1ns/10ps
`default_nettype none

module rxl_fifo #(
	parameter int WIDTH = 17,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic [$clog2(DEPTH+1)-1:0] level
);

	localparam int AW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH+1);

	// ==========================================================
	// Elaboration check
	if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1)
	begin : g_bad
		$error("rxl_fifo: DEPTH must be a power of two and at least 2");
	end

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0] wr_ptr_q;
	logic [AW-1:0] rd_ptr_q;
	logic [CW-1:0] count_q;
	logic [CW-1:0] count_d;
	logic push;
	logic pop;

	// Handshakes use the registered flags, so full and empty are honest
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_ptr_q];
	assign level = count_q;

	// Next occupancy
	always_comb
	begin
		count_d = count_q;
		if (push && !pop)
			count_d = count_q + CW'(1);
		else if (pop && !push)
			count_d = count_q - CW'(1);
	end

	// Storage, no reset needed
	always_ff @(posedge sys_clk)
	begin
		if (push)
			mem_q[wr_ptr_q] <= in_data;
	end

	// Pointers, occupancy and flags
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			count_q <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end
		else
		begin
			if (push)
				wr_ptr_q <= wr_ptr_q + AW'(1);
			if (pop)
				rd_ptr_q <= rd_ptr_q + AW'(1);
			count_q <= count_d;
			in_ready <= (count_d != CW'(DEPTH));
			out_valid <= (count_d != '0);
		end
	end

endmodule

`default_nettype wire

// ==== verilog/rxl_params.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the rx clock / LOS block
// Assumes: 100 MHz system clock, 32-bit AXI4-Lite register bus
// Notes: Definitions only
`ifndef RXL_PARAMS_SVH
`define RXL_PARAMS_SVH

// ==========================================================
// Register byte offsets
`define RXL_OFS_CONFIG_ZERO 8'h00
`define RXL_OFS_CONFIG_ONE 8'h04
`define RXL_OFS_POWERDOWN 8'h08
`define RXL_OFS_REF_CTRL 8'h0C
`define RXL_OFS_STATUS 8'h10
`define RXL_OFS_LOS_WORD 8'h14

// ==========================================================
// Field positions
`define RXL_B_CLK_SUBST 7
`define RXL_B_PD_TRISTATE 6
`define RXL_B_EDGE_SEL 4
`define RXL_B_FMT_LO 0
`define RXL_B_REF_EN 0
`define RXL_B_REF_FAST 1

// ==========================================================
// Reset values
`define RXL_RST_CONFIG_ZERO 8'h00
`define RXL_RST_CONFIG_ONE 8'h00
`define RXL_RST_REF_CTRL 2'h0

// ==========================================================
// Timing: times in ns as printed, counts derived from the clock period
`define RXL_SYS_PERIOD_NS 10
`define RXL_REF_SLOW_PERIOD_NS 125000
`define RXL_REF_FAST_PERIOD_NS 488
`define RXL_HALF_SLOW_CYC (`RXL_REF_SLOW_PERIOD_NS / 2 / `RXL_SYS_PERIOD_NS)
`define RXL_HALF_FAST_CYC (`RXL_REF_FAST_PERIOD_NS / 2 / `RXL_SYS_PERIOD_NS)

// ==========================================================
// Bus answers
`define RXL_RESP_OKAY 2'h0
`define RXL_RESP_SLVERR 2'h2

`endif

// ==== verilog/rxl_pkg.sv ====
// Purpose: Types shared by the rx clock / LOS block
// Assumes: Nothing
// Notes: Constants live in rxl_params.svh
package rxl_pkg;

	// ==========================================================
	// Receive system side formats
	typedef enum logic [1:0]
	{
		RXL_FMT_SINGLE_NRZ = 2'h0,
		RXL_FMT_DUAL_NRZ = 2'h1,
		RXL_FMT_DUAL_RZ = 2'h2,
		RXL_FMT_DUAL_SLICED = 2'h3
	} rxl_format_t;

	// ==========================================================
	// Write channel states, one-hot
	typedef enum logic [2:0]
	{
		RXL_WR_IDLE = 3'h1,
		RXL_WR_COLLECT = 3'h2,
		RXL_WR_RESP = 3'h4
	} rxl_wr_state_t;

endpackage

// ==== verilog/rxl_top.sv ====
// Purpose: Recovered rx clock / multiplex-function pins and serial line-loss stream
// Assumes: All pin inputs synchronous to sys_clk; AXI4-Lite register access
// Notes: Contract
//
// Implementation choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "rxl_params.svh"

module rxl_top
	import rxl_pkg::*;
#(
	parameter int NUM_CH = 17,
	parameter int FIFO_DEPTH = 16,
	parameter int HALF_SLOW_CYC = `RXL_HALF_SLOW_CYC,
	parameter int HALF_FAST_CYC = `RXL_HALF_FAST_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Per-channel recovered clock, sliced data and line loss level
	input wire logic [NUM_CH-1:0] recovered_clock_in,
	input wire logic [NUM_CH-1:0] rx_pos_in,
	input wire logic [NUM_CH-1:0] rx_neg_in,
	input wire logic [NUM_CH-1:0] line_loss_in,
	input wire logic reference_master_clock,
	// Line-loss snapshot words into the status FIFO
	input wire logic los_word_valid,
	output logic los_word_ready,
	input wire logic [NUM_CH-1:0] los_word_data,
	// Receive pins
	output logic [NUM_CH-1:0] recovered_rx_clock_out,
	output logic [NUM_CH-1:0] recovered_rx_clock_oe,
	output logic [NUM_CH-1:0] rx_positive_rail_data,
	output logic [NUM_CH-1:0] rx_negative_rail_data,
	output logic [NUM_CH-1:0] rx_data_oe,
	// Shared serial status pins
	output logic reference_clock_output,
	output logic serial_line_loss_status,
	output logic serial_line_loss_status_oe,
	output logic channel_zero_slot_marker,
	output logic channel_zero_slot_marker_oe
);

	localparam int SW = $clog2(NUM_CH);
	localparam int HW = $clog2(HALF_SLOW_CYC + 1);

	// ==========================================================
	// Elaboration checks
	if (NUM_CH < 2 || NUM_CH > 32 || HALF_FAST_CYC < 1 || HALF_SLOW_CYC < HALF_FAST_CYC)
	begin : g_bad
		$error("rxl_top: unsupported channel count or reference timing");
	end

	// ==========================================================
	// Register state
	logic [7:0] rx_config_zero_q;
	logic [7:0] rx_config_one_q;
	logic [NUM_CH-1:0] powerdown_q;
	logic [1:0] ref_ctrl_q;
	logic los_clock_substitute_select;
	logic powerdown_tristate_select;
	logic rx_clock_edge_select;
	rxl_format_t fmt;
	logic ref_enable;
	logic ref_fast;

	assign los_clock_substitute_select = rx_config_zero_q[`RXL_B_CLK_SUBST];
	assign powerdown_tristate_select = rx_config_zero_q[`RXL_B_PD_TRISTATE];
	assign rx_clock_edge_select = rx_config_one_q[`RXL_B_EDGE_SEL];
	assign fmt = rxl_format_t'(rx_config_one_q[`RXL_B_FMT_LO +: 2]);
	assign ref_enable = ref_ctrl_q[`RXL_B_REF_EN];
	assign ref_fast = ref_ctrl_q[`RXL_B_REF_FAST];

	// Byte-lane merge of a write into a stored word
	function automatic logic [31:0] merge_bytes(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++)
			if (be[i])
				r[8*i +: 8] = wd[8*i +: 8];
		return r;
	endfunction

	// Word-aligned register decode
	function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
		return (a[7:2] == ofs[7:2]);
	endfunction

	// ==========================================================
	// AXI4-Lite write path: address and data taken in either order
	rxl_wr_state_t wr_state_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic aw_held;
	logic w_held;
	logic do_write;
	logic wr_hit;
	logic [31:0] wr_merged;

	assign aw_held = !s_axi_awready;
	assign w_held = !s_axi_wready;
	assign do_write = (wr_state_q == RXL_WR_COLLECT) && aw_held && w_held;
	assign wr_hit = addr_is(aw_addr_q, `RXL_OFS_CONFIG_ZERO) || addr_is(aw_addr_q, `RXL_OFS_CONFIG_ONE)
		|| addr_is(aw_addr_q, `RXL_OFS_POWERDOWN) || addr_is(aw_addr_q, `RXL_OFS_REF_CTRL);

	// Channel handshakes and response
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			wr_state_q <= RXL_WR_IDLE;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RXL_RESP_OKAY;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end
		else
		begin
			case (wr_state_q)
				RXL_WR_IDLE:
				begin
					s_axi_awready <= 1'b1;
					s_axi_wready <= 1'b1;
					wr_state_q <= RXL_WR_COLLECT;
				end
				RXL_WR_COLLECT:
				begin
					if (s_axi_awvalid && s_axi_awready)
					begin
						aw_addr_q <= s_axi_awaddr;
						s_axi_awready <= 1'b0;
					end
					if (s_axi_wvalid && s_axi_wready)
					begin
						w_data_q <= s_axi_wdata;
						w_strb_q <= s_axi_wstrb;
						s_axi_wready <= 1'b0;
					end
					if (do_write)
					begin
						s_axi_bvalid <= 1'b1;
						s_axi_bresp <= wr_hit ? `RXL_RESP_OKAY : `RXL_RESP_SLVERR;
						wr_state_q <= RXL_WR_RESP;
					end
				end
				RXL_WR_RESP:
				begin
					if (s_axi_bready)
					begin
						s_axi_bvalid <= 1'b0;
						s_axi_awready <= 1'b1;
						s_axi_wready <= 1'b1;
						wr_state_q <= RXL_WR_COLLECT;
					end
				end
				default:
					wr_state_q <= RXL_WR_IDLE;
			endcase
		end
	end

	assign wr_merged = merge_bytes(32'h0000_0000, w_data_q, w_strb_q);

	// Configuration registers
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rx_config_zero_q <= `RXL_RST_CONFIG_ZERO;
			rx_config_one_q <= `RXL_RST_CONFIG_ONE;
			powerdown_q <= '0;
			ref_ctrl_q <= `RXL_RST_REF_CTRL;
		end
		else if (do_write)
		begin
			if (addr_is(aw_addr_q, `RXL_OFS_CONFIG_ZERO) && w_strb_q[0])
				rx_config_zero_q <= wr_merged[7:0];
			if (addr_is(aw_addr_q, `RXL_OFS_CONFIG_ONE) && w_strb_q[0])
				rx_config_one_q <= wr_merged[7:0];
			if (addr_is(aw_addr_q, `RXL_OFS_POWERDOWN))
				powerdown_q <= NUM_CH'(merge_bytes(32'(powerdown_q), w_data_q, w_strb_q));
			if (addr_is(aw_addr_q, `RXL_OFS_REF_CTRL) && w_strb_q[0])
				ref_ctrl_q <= wr_merged[1:0];
		end
	end

	// ==========================================================
	// AXI4-Lite read path: answer one cycle after the address is taken
	logic [SW-1:0] slot_q;
	logic [NUM_CH-1:0] los_word_q;
	logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;
	logic [31:0] rd_word;

	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (addr_is(s_axi_araddr, `RXL_OFS_CONFIG_ZERO))
			rd_word = 32'(rx_config_zero_q);
		else if (addr_is(s_axi_araddr, `RXL_OFS_CONFIG_ONE))
			rd_word = 32'(rx_config_one_q);
		else if (addr_is(s_axi_araddr, `RXL_OFS_POWERDOWN))
			rd_word = 32'(powerdown_q);
		else if (addr_is(s_axi_araddr, `RXL_OFS_REF_CTRL))
			rd_word = 32'(ref_ctrl_q);
		else if (addr_is(s_axi_araddr, `RXL_OFS_STATUS))
			rd_word = {16'h0000, 8'(fifo_level), 8'(slot_q)};
		else if (addr_is(s_axi_araddr, `RXL_OFS_LOS_WORD))
			rd_word = 32'(los_word_q);
	end

	// Address accepted only while no answer is pending
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RXL_RESP_OKAY;
		end
		else if (s_axi_rvalid)
		begin
			if (s_axi_rready)
			begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= (s_axi_araddr[7:2] <= `RXL_OFS_LOS_WORD >> 2) ? `RXL_RESP_OKAY : `RXL_RESP_SLVERR;
		end
		else
			s_axi_arready <= 1'b1;
	end

	// ==========================================================
	// Per-channel receive pins
	logic [NUM_CH-1:0] rclk_prev_q;
	logic [NUM_CH-1:0] active_edge;

	// Edge select 0: rising edge of the recovered clock, 1: falling
	assign active_edge = rx_clock_edge_select ? (rclk_prev_q & ~recovered_clock_in)
		: (~rclk_prev_q & recovered_clock_in);

	always_ff @(posedge sys_clk)
	begin
		if (rst)
			rclk_prev_q <= '0;
		else
			rclk_prev_q <= recovered_clock_in;
	end

	// Shared clock / multiplex pin; sliced format beats loss, powerdown beats both
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			recovered_rx_clock_out <= '0;
			recovered_rx_clock_oe <= '0;
		end
		else
		begin
			for (int n = 0; n < NUM_CH; n++)
			begin
				recovered_rx_clock_oe[n] <= !(powerdown_q[n] && powerdown_tristate_select);
				if (powerdown_q[n])
					recovered_rx_clock_out[n] <= 1'b0;
				else if (fmt == RXL_FMT_DUAL_SLICED)
					recovered_rx_clock_out[n] <= rx_pos_in[n] ^ rx_neg_in[n];
				else if (line_loss_in[n])
					recovered_rx_clock_out[n] <= los_clock_substitute_select ? reference_master_clock : 1'b1;
				else
					recovered_rx_clock_out[n] <= recovered_clock_in[n];
			end
		end
	end

	// Data pins follow the active edge; sliced mode passes data straight through
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			rx_positive_rail_data <= '0;
			rx_negative_rail_data <= '0;
			rx_data_oe <= '0;
		end
		else
		begin
			for (int n = 0; n < NUM_CH; n++)
			begin
				rx_data_oe[n] <= !(powerdown_q[n] && powerdown_tristate_select);
				if (powerdown_q[n])
				begin
					rx_positive_rail_data[n] <= 1'b0;
					rx_negative_rail_data[n] <= 1'b0;
				end
				else if (fmt == RXL_FMT_DUAL_SLICED || active_edge[n])
				begin
					rx_positive_rail_data[n] <= rx_pos_in[n];
					// Single rail: the negative pin carries the loss flag, active high
					rx_negative_rail_data[n] <= (fmt == RXL_FMT_SINGLE_NRZ) ? line_loss_in[n] : rx_neg_in[n];
				end
			end
		end
	end

	// ==========================================================
	// Status FIFO: one snapshot word per seventeen-slot frame
	logic fifo_out_valid;
	logic fifo_pop;
	logic [NUM_CH-1:0] fifo_out_data;

	rxl_fifo #(
		.WIDTH(NUM_CH),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.sys_clk(sys_clk),
		.rst(rst),
		.in_valid(los_word_valid),
		.in_ready(los_word_ready),
		.in_data(los_word_data),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data),
		.level(fifo_level)
	);

	// ==========================================================
	// Reference clock divider
	logic [HW-1:0] half_cnt_q;
	logic ref_rise;
	logic [HW-1:0] half_limit;

	// Fast period truncates to whole cycles, so it runs slightly above 2.048 MHz
	assign half_limit = ref_fast ? HW'(HALF_FAST_CYC - 1) : HW'(HALF_SLOW_CYC - 1);
	assign ref_rise = ref_enable && (half_cnt_q >= half_limit) && !reference_clock_output;

	always_ff @(posedge sys_clk)
	begin
		if (rst || !ref_enable)
		begin
			half_cnt_q <= '0;
			reference_clock_output <= 1'b0;
		end
		else if (half_cnt_q >= half_limit)
		begin
			half_cnt_q <= '0;
			reference_clock_output <= !reference_clock_output;
		end
		else
			half_cnt_q <= half_cnt_q + HW'(1);
	end

	// ==========================================================
	// Serial loss stream and channel-zero marker
	logic [SW-1:0] slot_next;
	logic [NUM_CH-1:0] word_next;

	assign slot_next = (slot_q == SW'(NUM_CH - 1)) ? '0 : slot_q + SW'(1);
	assign fifo_pop = ref_rise && (slot_next == '0) && fifo_out_valid;
	// A fresh word is taken at slot 0; without one the last word repeats
	assign word_next = fifo_pop ? fifo_out_data : los_word_q;

	// Everything here changes only with the reference rising edge, or, save los_word_q, returns to its reset value when the reference is switched off
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			slot_q <= SW'(NUM_CH - 1);
			los_word_q <= '0;
			serial_line_loss_status <= 1'b0;
			channel_zero_slot_marker <= 1'b0;
		end
		else if (!ref_enable)
		begin
			slot_q <= SW'(NUM_CH - 1);
			serial_line_loss_status <= 1'b0;
			channel_zero_slot_marker <= 1'b0;
		end
		else if (ref_rise)
		begin
			slot_q <= slot_next;
			los_word_q <= word_next;
			serial_line_loss_status <= word_next[slot_next];
			channel_zero_slot_marker <= (slot_next == '0);
		end
	end

	// Both serial pins float while the reference is off
	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			serial_line_loss_status_oe <= 1'b0;
			channel_zero_slot_marker_oe <= 1'b0;
		end
		else
		begin
			serial_line_loss_status_oe <= ref_enable;
			channel_zero_slot_marker_oe <= ref_enable;
		end
	end

endmodule

`default_nettype wire
